// ===== shared/crcm_pkg.sv
// Purpose: Constants and types for the core register context model
// Assumes: 16-bit data, byte addresses on the register port
// Notes: Special registers sit in one word array from REG_SFR_BASE
package crcm_pkg;
    // Sizes
    localparam int PC_W = 23;
    localparam int INSTR_W = 24;
    localparam int DATA_W = 16;
    localparam int N_CTX = 5;
    localparam int N_ALT_W = 15;
    // Working registers at 0x0000..0x001e, W15 slot is the stack pointer
    localparam logic [15:0] REG_W_BASE = 16'h0000;
    localparam logic [15:0] REG_STACK_POINTER = 16'h001e;
    // Word array of special registers, index = (addr - base) / 2
    localparam logic [15:0] REG_SFR_BASE = 16'h0020;
    localparam logic [4:0] SFR_STACK_LIMIT = 5'h00;
    localparam logic [4:0] SFR_ACC_A_LOW = 5'h01;
    localparam logic [4:0] SFR_ACC_A_HIGH = 5'h02;
    localparam logic [4:0] SFR_ACC_A_UPPER = 5'h03;
    localparam logic [4:0] SFR_ACC_B_LOW = 5'h04;
    localparam logic [4:0] SFR_ACC_B_HIGH = 5'h05;
    localparam logic [4:0] SFR_ACC_B_UPPER = 5'h06;
    localparam logic [4:0] SFR_TABLE_PAGE = 5'h07;
    localparam logic [4:0] SFR_EXT_READ_PAGE = 5'h08;
    localparam logic [4:0] SFR_REPEAT_COUNTER = 5'h09;
    localparam logic [4:0] SFR_LOOP_COUNTER = 5'h0a;
    localparam logic [4:0] SFR_LOOP_END_LOW = 5'h0b;
    localparam logic [4:0] SFR_LOOP_END_HIGH = 5'h0c;
    localparam logic [4:0] SFR_ALU_FLAGS = 5'h0d;
    localparam logic [4:0] SFR_CORE_CONTROL = 5'h0e;
    localparam logic [4:0] SFR_X_MOD_START = 5'h0f;
    localparam logic [4:0] SFR_X_MOD_END = 5'h10;
    localparam logic [4:0] SFR_Y_MOD_START = 5'h11;
    localparam logic [4:0] SFR_Y_MOD_END = 5'h12;
    localparam logic [4:0] SFR_ADDR_CTRL = 5'h13;
    localparam logic [4:0] SFR_X_BITREV = 5'h14;
    localparam int N_SFR = 21;
    localparam logic [15:0] REG_SFR_END = 16'h004a;
    // Separately held registers
    localparam logic [15:0] REG_PC_LOW = 16'h0060;
    localparam logic [15:0] REG_PC_HIGH = 16'h0062;
    localparam logic [15:0] REG_LOOP_START_LOW = 16'h0064;
    localparam logic [15:0] REG_LOOP_START_HIGH = 16'h0066;
    localparam logic [15:0] REG_ALT_CONFIG = 16'h0068;
    localparam logic [15:0] REG_CONTEXT_STATUS = 16'h006a;
    // Field positions
    localparam int ALU_RA_BIT = 4;
    localparam int ALU_DA_BIT = 9;
    localparam int ALU_LEVEL_LSB = 5;
    localparam int CTRL_X_MOD_EN = 15;
    localparam int CTRL_Y_MOD_EN = 14;
    localparam int CTRL_VIS_EN = 13;
    localparam int CTRL_X_REG_LSB = 0;
    localparam int CTRL_Y_REG_LSB = 4;
    localparam int BITREV_EN = 15;
    localparam int STAT_CUR_LSB = 0;
    localparam int STAT_MAN_LSB = 8;
    // Reset values
    localparam logic [15:0] RST_CORE_CONTROL = 16'h0020;
    // Step sizes in bytes
    localparam logic [15:0] SP_STEP = 16'h0002;
    localparam logic [15:0] SP_IRQ_STEP = 16'h0004;
    localparam logic [22:0] PC_STEP = 23'h000002;
    // Operand addressing modes
    typedef enum logic [2:0] {
        MODE_INHERENT = 3'b000,
        MODE_RELATIVE = 3'b001,
        MODE_LITERAL = 3'b010,
        MODE_MEM_DIRECT = 3'b011,
        MODE_REG_DIRECT = 3'b100,
        MODE_REG_INDIRECT = 3'b101
    } crcm_mode_t;
endpackage

// ===== hdl/crcm_core_regs.sv
// Purpose: Programmer-visible register model, contexts and data addressing
// Assumes: Core pulses are one cycle; X and Y steps use different registers
// Notes: Data port is the memory-mapped view of the working, special, PC, loop-start, alternate-config and context-status registers
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module crcm_core_regs
    import crcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Fetch and flow
    input wire logic fetch_valid,
    input wire logic [23:0] fetch_word,
    input wire logic pc_load,
    input wire logic [22:0] pc_target,
    input wire logic dword_move,
    input wire logic table_op,
    input wire logic loop_begin,
    input wire logic [22:0] loop_begin_addr,
    output logic [22:0] pc_out,
    output logic [23:0] instr_out,
    output logic [2:0] addr_mode,
    output logic core_stall,
    // Interrupts, calls and context swap
    input wire logic irq_take,
    input wire logic [2:0] irq_level,
    input wire logic irq_return,
    input wire logic [2:0] irq_ret_level,
    input wire logic call_push,
    input wire logic call_pop,
    input wire logic context_swap_instr,
    input wire logic [2:0] context_swap_idx,
    output logic [2:0] current_context_index,
    // Address generators
    input wire logic x_step,
    input wire logic [3:0] x_reg,
    input wire logic [15:0] x_inc,
    input wire logic y_step,
    input wire logic [3:0] y_reg,
    input wire logic [15:0] y_inc,
    output logic [15:0] x_addr,
    output logic x_prog_vis,
    output logic [22:0] x_prog_addr,
    output logic [15:0] y_addr
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [N_CTX-1:0][N_ALT_W-1:0][15:0] wreg;
        logic [15:0] stack_pointer_reg;
        logic [N_SFR-1:0][15:0] sfr;
        logic [22:0] pc;
        logic [22:0] loop_start;
        logic [11:0] alt_context_config_word;
        logic [2:0] cur_ctx;
        logic [2:0] man_ctx;
        logic [7:0][2:0] ret_ctx;
        logic [23:0] instr;
        logic [2:0] mode;
        logic stall;
        logic [15:0] rdata;
        logic [15:0] x_ea;
        logic x_vis;
        logic [22:0] vis_addr;
        logic [15:0] y_ea;
    } crcm_state_t;

    crcm_state_t s_ff;
    crcm_state_t nxt_s;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] crcm_rev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    function automatic logic [15:0] crcm_wrap(input logic [15:0] ea, input logic [15:0] inc,
                                              input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] t;
        t = ea + inc;
        if (!inc[15] && (t > hi))
        begin
            t = lo;
        end
        else if (inc[15] && (t < lo))
        begin
            t = hi;
        end
        return t;
    endfunction

    function automatic crcm_mode_t crcm_decode(input logic [23:0] w);
        crcm_mode_t m;
        case (w[6:4])
            3'b000: m = MODE_INHERENT;
            3'b001: m = MODE_RELATIVE;
            3'b010: m = MODE_LITERAL;
            3'b011: m = MODE_MEM_DIRECT;
            3'b100: m = MODE_REG_DIRECT;
            3'b101: m = MODE_REG_INDIRECT;
            default: m = MODE_INHERENT;
        endcase
        return m;
    endfunction

    // ==========================================================
    // Next state
    logic [15:0] sfr_off;
    logic [4:0] sfr_idx;
    logic sfr_hit;
    logic [15:0] ctrl;
    logic [15:0] x_cur;
    logic [15:0] x_nxt;
    logic [15:0] y_cur;
    logic [15:0] y_nxt;
    logic [15:0] alu_rd;
    logic [2:0] alt_hit;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.rdata = '0;
        nxt_s.stall = 1'b0;
        ctrl = s_ff.sfr[SFR_ADDR_CTRL];
        sfr_off = reg_addr - REG_SFR_BASE;
        sfr_idx = sfr_off[5:1];
        sfr_hit = (reg_addr >= REG_SFR_BASE) && (reg_addr < REG_SFR_END) && !reg_addr[0];
        x_cur = '0;
        x_nxt = '0;
        y_cur = '0;
        y_nxt = '0;
        alt_hit = 3'h0;
        alu_rd = s_ff.sfr[SFR_ALU_FLAGS];
        alu_rd[ALU_RA_BIT] = (s_ff.sfr[SFR_REPEAT_COUNTER] != 16'h0000);
        alu_rd[ALU_DA_BIT] = (s_ff.sfr[SFR_LOOP_COUNTER] != 16'h0000);

        // Data-space read, answered in the next cycle
        if (reg_rd)
        begin
            if (reg_addr < REG_STACK_POINTER && !reg_addr[0])
            begin
                nxt_s.rdata = s_ff.wreg[s_ff.cur_ctx][reg_addr[4:1]];
            end
            else if (reg_addr == REG_STACK_POINTER)
            begin
                nxt_s.rdata = s_ff.stack_pointer_reg;
            end
            else if (sfr_hit)
            begin
                nxt_s.rdata = (sfr_idx == SFR_ALU_FLAGS) ? alu_rd : s_ff.sfr[sfr_idx];
            end
            else
            begin
                case (reg_addr)
                    REG_PC_LOW: nxt_s.rdata = s_ff.pc[15:0];
                    REG_PC_HIGH: nxt_s.rdata = {9'h000, s_ff.pc[22:16]};
                    REG_LOOP_START_LOW: nxt_s.rdata = s_ff.loop_start[15:0];
                    REG_LOOP_START_HIGH: nxt_s.rdata = {9'h000, s_ff.loop_start[22:16]};
                    REG_ALT_CONFIG: nxt_s.rdata = {4'h0, s_ff.alt_context_config_word};
                    REG_CONTEXT_STATUS:
                        nxt_s.rdata = {5'h00, s_ff.man_ctx, 5'h00, s_ff.cur_ctx};
                    default: nxt_s.rdata = '0;
                endcase
            end
        end

        // Data-space write
        if (reg_wr)
        begin
            if (reg_addr < REG_STACK_POINTER && !reg_addr[0])
            begin
                nxt_s.wreg[s_ff.cur_ctx][reg_addr[4:1]] = reg_wdata;
            end
            else if (reg_addr == REG_STACK_POINTER)
            begin
                nxt_s.stack_pointer_reg = reg_wdata;
            end
            else if (sfr_hit)
            begin
                nxt_s.sfr[sfr_idx] = reg_wdata;
            end
            else
            begin
                case (reg_addr)
                    REG_PC_LOW: nxt_s.pc[15:0] = reg_wdata;
                    REG_PC_HIGH: nxt_s.pc[22:16] = reg_wdata[6:0];
                    REG_ALT_CONFIG: nxt_s.alt_context_config_word = reg_wdata[11:0];
                    default: nxt_s.stall = nxt_s.stall;
                endcase
            end
        end

        // Fetch, decode and loops
        if (fetch_valid)
        begin
            nxt_s.instr = fetch_word;
            nxt_s.mode = crcm_decode(fetch_word);
            if (s_ff.sfr[SFR_REPEAT_COUNTER] != 16'h0000)
            begin
                nxt_s.sfr[SFR_REPEAT_COUNTER] = s_ff.sfr[SFR_REPEAT_COUNTER] - 16'h0001;
            end
            else if ((s_ff.sfr[SFR_LOOP_COUNTER] != 16'h0000)
                     && (s_ff.pc == {s_ff.sfr[SFR_LOOP_END_HIGH][6:0], s_ff.sfr[SFR_LOOP_END_LOW]}))
            begin
                nxt_s.pc = s_ff.loop_start;
                nxt_s.sfr[SFR_LOOP_COUNTER] = s_ff.sfr[SFR_LOOP_COUNTER] - 16'h0001;
            end
            else
            begin
                nxt_s.pc = s_ff.pc + PC_STEP;
            end
        end
        if (loop_begin)
        begin
            nxt_s.loop_start = loop_begin_addr;
        end
        if (pc_load)
        begin
            nxt_s.pc = pc_target;
        end
        nxt_s.stall = pc_load || dword_move || table_op || s_ff.x_vis;

        // X generator: modulo, bit-reversed, visibility window
        if (x_step)
        begin
            x_cur = (x_reg == 4'hf) ? s_ff.stack_pointer_reg : s_ff.wreg[s_ff.cur_ctx][x_reg];
            if (ctrl[CTRL_X_MOD_EN] && (x_reg == ctrl[CTRL_X_REG_LSB +: 4]))
            begin
                x_nxt = crcm_wrap(x_cur, x_inc, s_ff.sfr[SFR_X_MOD_START],
                                  s_ff.sfr[SFR_X_MOD_END]);
            end
            else if (s_ff.sfr[SFR_X_BITREV][BITREV_EN])
            begin
                x_nxt = crcm_rev(crcm_rev(x_cur)
                                 + crcm_rev({1'b0, s_ff.sfr[SFR_X_BITREV][14:0]}));
            end
            else
            begin
                x_nxt = x_cur + x_inc;
            end
            if (x_reg == 4'hf)
            begin
                nxt_s.stack_pointer_reg = x_nxt;
            end
            else
            begin
                nxt_s.wreg[s_ff.cur_ctx][x_reg] = x_nxt;
            end
            nxt_s.x_ea = x_cur;
            nxt_s.x_vis = ctrl[CTRL_VIS_EN] && x_cur[15];
            nxt_s.vis_addr = {1'b0, s_ff.sfr[SFR_EXT_READ_PAGE][7:0], x_cur[14:1]};
        end
        else
        begin
            nxt_s.x_vis = 1'b0;
        end

        // Y generator: dual-operand fetch with modulo
        if (y_step && (y_reg != 4'hf))
        begin
            y_cur = s_ff.wreg[s_ff.cur_ctx][y_reg];
            if (ctrl[CTRL_Y_MOD_EN] && (y_reg == ctrl[CTRL_Y_REG_LSB +: 4]))
            begin
                y_nxt = crcm_wrap(y_cur, y_inc, s_ff.sfr[SFR_Y_MOD_START],
                                  s_ff.sfr[SFR_Y_MOD_END]);
            end
            else
            begin
                y_nxt = y_cur + y_inc;
            end
            nxt_s.wreg[s_ff.cur_ctx][y_reg] = y_nxt;
            nxt_s.y_ea = y_cur;
        end

        // Stack pointer for calls
        if (call_push)
        begin
            nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg + SP_STEP;
        end
        else if (call_pop)
        begin
            nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg - SP_STEP;
        end

        // Context selection; other copies are never touched here
        for (int n = 1; n < N_CTX; n++)
        begin
            if (irq_level != 3'h0
                && s_ff.alt_context_config_word[3*(n-1) +: 3] == irq_level)
            begin
                alt_hit = n[2:0];
            end
        end
        if (irq_take)
        begin
            nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg + SP_IRQ_STEP;
            nxt_s.sfr[SFR_ALU_FLAGS][ALU_LEVEL_LSB +: 3] = irq_level;
            nxt_s.ret_ctx[irq_level] = s_ff.cur_ctx;
            if (alt_hit != 3'h0)
            begin
                nxt_s.cur_ctx = alt_hit;
            end
        end
        else if (irq_return)
        begin
            nxt_s.stack_pointer_reg = s_ff.stack_pointer_reg - SP_IRQ_STEP;
            nxt_s.cur_ctx = s_ff.ret_ctx[s_ff.sfr[SFR_ALU_FLAGS][ALU_LEVEL_LSB +: 3]];
            nxt_s.sfr[SFR_ALU_FLAGS][ALU_LEVEL_LSB +: 3] = irq_ret_level;
        end
        else if (context_swap_instr && (context_swap_idx < N_CTX[2:0]))
        begin
            nxt_s.cur_ctx = context_swap_idx;
            nxt_s.man_ctx = context_swap_idx;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_ff <= '0;
            s_ff.sfr[SFR_CORE_CONTROL] <= RST_CORE_CONTROL;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = s_ff.rdata;
    assign pc_out = s_ff.pc;
    assign instr_out = s_ff.instr;
    assign addr_mode = s_ff.mode;
    assign core_stall = s_ff.stall;
    assign current_context_index = s_ff.cur_ctx;
    assign x_addr = s_ff.x_ea;
    assign x_prog_vis = s_ff.x_vis;
    assign x_prog_addr = s_ff.vis_addr;
    assign y_addr = s_ff.y_ea;

endmodule

// ===== testbench/crcm_core_regs_chk.sv
// Purpose: Port-level checks for the core register context model
// Assumes: Bound to crcm_core_regs, one clock domain
// Notes: Stall, fetch, context and read-port relations
`timescale 1ns/1ns
module crcm_core_regs_chk
    import crcm_pkg::*;
(
    // Clock and reset
    input logic ref_clk,
    input logic sys_rst,
    // Register port
    input logic reg_rd,
    input logic [15:0] reg_rdata,
    // Fetch and flow
    input logic fetch_valid,
    input logic [23:0] fetch_word,
    input logic pc_load,
    input logic [22:0] pc_target,
    input logic dword_move,
    input logic table_op,
    input logic [22:0] pc_out,
    input logic [23:0] instr_out,
    input logic [2:0] addr_mode,
    input logic core_stall,
    // Contexts
    input logic irq_take,
    input logic irq_return,
    input logic context_swap_instr,
    input logic [2:0] context_swap_idx,
    input logic [2:0] current_context_index,
    // Address generator
    input logic x_step,
    input logic [15:0] x_addr,
    input logic x_prog_vis
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Sequences
    sequence s_stall_cause;
        pc_load || dword_move || table_op;
    endsequence
    sequence s_ctx_quiet;
        !irq_take && !irq_return && !context_swap_instr;
    endsequence
    // ==========================================
    // Properties
    property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
    property p_stall; s_stall_cause |=> core_stall; endproperty
    property p_no_stall; !(pc_load || dword_move || table_op) && !x_prog_vis |=> !core_stall; endproperty
    property p_pc_load; pc_load |=> pc_out == $past(pc_target); endproperty
    property p_instr; fetch_valid |=> instr_out == $past(fetch_word); endproperty
    property p_mode; fetch_valid && fetch_word[6:4] > 3'd5 |=> addr_mode == 3'b000; endproperty
    property p_swap;
        context_swap_instr && context_swap_idx <= 3'd4 && !irq_take && !irq_return
            |=> current_context_index == $past(context_swap_idx);
    endproperty
    property p_ctx_hold; s_ctx_quiet |=> $stable(current_context_index); endproperty
    property p_x_hold; !x_step |=> $stable(x_addr); endproperty
    property p_vis_stall; x_prog_vis |=> core_stall; endproperty
    // ==========================================
    // Assertions
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
    a_stall: assert property (p_stall) else $error("stall missing");
    a_no_stall: assert property (p_no_stall) else $error("stall without cause");
    a_pc_load: assert property (p_pc_load) else $error("pc load wrong");
    a_instr: assert property (p_instr) else $error("instruction word wrong");
    a_mode: assert property (p_mode) else $error("mode not inherent");
    a_swap: assert property (p_swap) else $error("swap index wrong");
    a_ctx_hold: assert property (p_ctx_hold) else $error("context moved");
    a_x_hold: assert property (p_x_hold) else $error("x address moved");
    a_vis_stall: assert property (p_vis_stall) else $error("window read did not stall");
endmodule

// ===== testbench/crcm_core_regs_tb.sv
// Purpose: Directed bench for the core register context model
// Assumes: Register port with one-cycle read data
// Notes: Core pulses share one vector
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            $display("ERROR %s exp %h got %h", nm, e, g); \
            errors++; \
        end \
    end
module crcm_core_regs_tb
    import crcm_pkg::*;
;
    localparam logic [11:0] F_IRQ = 12'h800, F_RET = 12'h400, F_PUSH = 12'h200, F_POP = 12'h100;
    localparam logic [11:0] F_SWAP = 12'h080, F_X = 12'h040, F_Y = 12'h020, F_DW = 12'h010;
    localparam logic [11:0] F_TB = 12'h008, F_FETCH = 12'h004, F_LOAD = 12'h002, F_LOOP = 12'h001;
    logic ref_clk = 1'b0;
    logic sys_rst, reg_wr, reg_rd, irq_take, irq_return, call_push, call_pop, context_swap_instr;
    logic x_step, y_step, dword_move, table_op, fetch_valid, pc_load, loop_begin, core_stall, x_prog_vis;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, x_inc, y_inc, x_addr, y_addr;
    logic [23:0] fetch_word, instr_out;
    logic [22:0] pc_target, loop_begin_addr, pc_out, x_prog_addr;
    logic [2:0] irq_level, irq_ret_level, context_swap_idx, current_context_index, addr_mode;
    logic [3:0] x_reg, y_reg;
    logic [11:0] pul;
    int errors = 0;
    int tests_run = 0;
    assign {irq_take, irq_return, call_push, call_pop, context_swap_instr, x_step, y_step, dword_move,
        table_op, fetch_valid, pc_load, loop_begin} = pul;
    always #5 ref_clk = ~ref_clk;
    crcm_core_regs u_crcm_core_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word), .pc_load(pc_load), .pc_target(pc_target),
        .dword_move(dword_move), .table_op(table_op), .loop_begin(loop_begin),
        .loop_begin_addr(loop_begin_addr), .pc_out(pc_out), .instr_out(instr_out), .addr_mode(addr_mode),
        .core_stall(core_stall), .irq_take(irq_take), .irq_level(irq_level), .irq_return(irq_return),
        .irq_ret_level(irq_ret_level), .call_push(call_push), .call_pop(call_pop),
        .context_swap_instr(context_swap_instr), .context_swap_idx(context_swap_idx),
        .current_context_index(current_context_index), .x_step(x_step), .x_reg(x_reg), .x_inc(x_inc),
        .y_step(y_step), .y_reg(y_reg), .y_inc(y_inc), .x_addr(x_addr), .x_prog_vis(x_prog_vis),
        .x_prog_addr(x_prog_addr), .y_addr(y_addr));
    // ==========================================
    // Tasks
    task automatic step();
        @(posedge ref_clk);
    endtask
    task automatic fire(input logic [11:0] p);
        pul <= p;
        step();
        pul <= 12'h000;
        step();
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step();
        reg_wr <= 1'b0;
        step();
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] v;
        reg_addr <= a;
        reg_rd <= 1'b1;
        step();
        reg_rd <= 1'b0;
        step();
        v = reg_rdata;
        `CHK("reg_rdata", e, v);
    endtask
    task automatic swap(input logic [2:0] i);
        context_swap_idx <= i;
        fire(F_SWAP);
    endtask
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Sequence of tests
    initial
    begin
        repeat (20000) step();
        errors++;
        wrap_up();
    end
    initial
    begin
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, pul, fetch_word, pc_target, loop_begin_addr} = '0;
        {irq_level, irq_ret_level, context_swap_idx, x_reg, x_inc, y_reg, y_inc} = '0;
        repeat (3) step();
        sys_rst <= 1'b0;
        rd_chk(16'h003c, RST_CORE_CONTROL);
        rd_chk(16'h0080, 16'h0000);
        wr(16'h0002, 16'h1111);
        rd_chk(16'h0002, 16'h1111);
        swap(3'd2);
        rd_chk(16'h0002, 16'h0000);
        wr(16'h0002, 16'h2222);
        swap(3'd0);
        rd_chk(16'h0002, 16'h1111);
        swap(3'd2);
        rd_chk(16'h0002, 16'h2222);
        rd_chk(16'h006a, 16'h0202);
        swap(3'd5);
        `CHK("context", 3'd2, current_context_index);
        swap(3'd0);
        wr(16'h0068, 16'h0003);
        wr(16'h001e, 16'h0800);
        irq_level <= 3'd3;
        fire(F_IRQ);
        `CHK("context", 3'd1, current_context_index);
        rd_chk(16'h001e, 16'h0804);
        rd_chk(16'h003a, 16'h0060);
        fire(F_RET);
        `CHK("context", 3'd0, current_context_index);
        rd_chk(16'h001e, 16'h0800);
        fire(F_PUSH);
        rd_chk(16'h001e, 16'h0802);
        fire(F_POP);
        rd_chk(16'h001e, 16'h0800);
        for (int m = 0; m < 8; m++)
        begin
            fetch_word <= {17'h00000, 3'(m), 4'h0};
            fire(F_FETCH);
            `CHK("addr_mode", (m < 6) ? 3'(m) : 3'b000, addr_mode);
        end
        pc_target <= 23'h7ffffe;
        fire(F_LOAD);
        `CHK("pc", 23'h7ffffe, pc_out);
        rd_chk(16'h0062, 16'h007f);
        fetch_word <= 24'hfedcba;
        fire(F_FETCH);
        `CHK("pc", 23'h000000, pc_out);
        `CHK("instr", 24'hfedcba, instr_out);
        fire(F_DW);
        `CHK("stall", 1'b1, core_stall);
        step();
        `CHK("stall", 1'b0, core_stall);
        fire(F_TB);
        `CHK("stall", 1'b1, core_stall);
        loop_begin_addr <= 23'h123456;
        fire(F_LOOP);
        wr(16'h0064, 16'hffff);
        rd_chk(16'h0064, 16'h3456);
        rd_chk(16'h0066, 16'h0012);
        wr(16'h0004, 16'h0100);
        x_reg <= 4'h2;
        x_inc <= 16'h0002;
        fire(F_X);
        `CHK("x_addr", 16'h0100, x_addr);
        rd_chk(16'h0004, 16'h0102);
        wr(16'h003e, 16'h0100);
        wr(16'h0040, 16'h0102);
        wr(16'h0046, 16'h8002);
        fire(F_X);
        `CHK("x_addr", 16'h0102, x_addr);
        rd_chk(16'h0004, 16'h0100);
        y_reg <= 4'h3;
        y_inc <= 16'h0004;
        fire(F_Y);
        fire(F_Y);
        `CHK("y_addr", 16'h0004, y_addr);
        // Bit-reversed stepping on a non-modulo register
        x_reg <= 4'h4;
        wr(16'h0048, 16'h8008);
        fire(F_X);
        fire(F_X);
        `CHK("x_addr", 16'h0008, x_addr);
        rd_chk(16'h0008, 16'h0004);
        // Program space window through the X generator
        wr(16'h0030, 16'h0005);
        wr(16'h0046, 16'ha002);
        wr(16'h000a, 16'h8006);
        x_reg <= 4'h5;
        fire(F_X);
        `CHK("x_prog_vis", 1'b1, x_prog_vis);
        `CHK("x_prog_addr", 23'h014003, x_prog_addr);
        step();
        `CHK("stall", 1'b1, core_stall);
        `CHK("x_prog_vis", 1'b0, x_prog_vis);
        // Repeat holds the PC, then a block loop jumps back
        wr(16'h0032, 16'h0002);
        rd_chk(16'h003a, 16'h0010);
        fire(F_FETCH);
        fire(F_FETCH);
        `CHK("pc", 23'h000000, pc_out);
        rd_chk(16'h0032, 16'h0000);
        wr(16'h0036, 16'h0002);
        wr(16'h0034, 16'h0001);
        rd_chk(16'h003a, 16'h0200);
        fire(F_FETCH);
        fire(F_FETCH);
        `CHK("pc", 23'h123456, pc_out);
        rd_chk(16'h0034, 16'h0000);
        wrap_up();
    end
endmodule
bind crcm_core_regs crcm_core_regs_chk u_crcm_core_regs_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .pc_load(pc_load), .pc_target(pc_target), .dword_move(dword_move), .table_op(table_op),
    .pc_out(pc_out), .instr_out(instr_out), .addr_mode(addr_mode), .core_stall(core_stall),
    .irq_take(irq_take), .irq_return(irq_return), .context_swap_instr(context_swap_instr),
    .context_swap_idx(context_swap_idx), .current_context_index(current_context_index),
    .x_step(x_step), .x_addr(x_addr), .x_prog_vis(x_prog_vis));
